// ### design/fcb_defs.vh
// fcb_defs.vh: register indices, field layout and reset values of the
// channel B coefficient bank; definitions only, no logic
`ifndef FCB_DEFS_VH
`define FCB_DEFS_VH

// word indices; byte address is four times the index
`define FCB_IDX_CTAP      12'h450
`define FCB_IDX_TAP6      12'h453
`define FCB_IDX_TAP7      12'h455
`define FCB_IDX_TAP8      12'h457
`define FCB_IDX_TAP9      12'h459
`define FCB_IDX_CTRL      12'h460
`define FCB_IDX_STAT      12'h461
`define FCB_TAP_STEP      2

// apb geometry
`define FCB_AW            14
`define FCB_IW            12
`define FCB_DW            32

// center tap: 24-bit register, 18-bit coefficient
`define FCB_CTAP_W        24
`define FCB_CTAP_CW       18
`define FCB_CTAP_RMASK    24'hffffff
// outer taps: 16-bit register, 12-bit coefficient
`define FCB_OTAP_W        16
`define FCB_OTAP_CW       12
`define FCB_OTAP_N        4
`define FCB_OTAP_RMASK    16'hffff
// last tap reads its coefficient msb as zero
`define FCB_TAP9_RMASK    16'hf7ff

// control fields
`define FCB_CTRL_W        2
`define FCB_CTRL_DUAL     0
`define FCB_CTRL_HOLD     1

// reset values
`define FCB_CTAP_RST      24'h000000
`define FCB_OTAP_RST      16'h0000
`define FCB_CTRL_RST      2'h0

`endif

// ### design/fcb_apb_if.v
// fcb_apb_if.v: apb slave front end of the coefficient bank
// assumes an apb master on pclk; read data is sampled in the setup cycle
`timescale 1ns/10ps
`include "fcb_defs.vh"
module fcb_apb_if (
	// clock and reset
	input  wire                 pclk,
	input  wire                 presetn,
	// apb
	input  wire                 psel,
	input  wire                 penable,
	input  wire                 pwrite,
	input  wire [`FCB_AW-1:0]   paddr,
	output wire                 pready,
	output reg  [`FCB_DW-1:0]   prdata,
	output reg                  pslverr,
	// register file side
	output wire [`FCB_IW-1:0]   idx,
	input  wire                 hit,
	input  wire                 wr_ok,
	input  wire [`FCB_DW-1:0]   rd_data,
	output wire                 wr_stb
);
	wire setup;
	wire ok;

	assign idx    = paddr[`FCB_AW-1:2];
	// misaligned words are treated as unmapped
	assign ok     = hit && (paddr[1:0] == 2'h0);
	assign setup  = psel && !penable;
	// zero wait states: every access phase completes at once
	assign pready = 1'b1;
	assign wr_stb = psel && penable && pwrite && ok && wr_ok;

	// answer is captured in setup so prdata comes from a flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= {`FCB_DW{1'b0}};
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= (ok && !pwrite) ? rd_data : {`FCB_DW{1'b0}};
			pslverr <= !ok || (pwrite && !wr_ok);
		end
	end
endmodule

// ### design/fcb_coeff_reg.v
// fcb_coeff_reg.v: one read/write coefficient register with readback mask
// assumes a one-cycle write strobe on pclk
`timescale 1ns/10ps
`include "fcb_defs.vh"
module fcb_coeff_reg #(
	parameter             W     = `FCB_OTAP_W,
	parameter             CW    = `FCB_OTAP_CW,
	parameter [W-1:0]     RMASK = {W{1'b1}}
) (
	// clock and reset
	input  wire           pclk,
	input  wire           presetn,
	// write port
	input  wire           wr_en,
	input  wire [W-1:0]   wdata,
	// contents
	output reg  [W-1:0]   q_r,
	output wire [W-1:0]   rdata,
	output wire [CW-1:0]  coeff,
	output reg            wrote_r
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r     <= {W{1'b0}};
			wrote_r <= 1'b0;
		end else if (wr_en) begin
			q_r     <= wdata;
			wrote_r <= 1'b1;
		end
	end

	// the mask only shapes readback; the filter sees the stored value
	assign rdata = q_r & RMASK;
	assign coeff = q_r[CW-1:0];
endmodule

// ### design/fcb_coeff_bank.v
// fcb_coeff_bank.v: channel B equalizer coefficient bank, taps five to nine
// assumes an apb master on pclk and a filter datapath that reads the taps
`timescale 1ns/10ps
`include "fcb_defs.vh"
module fcb_coeff_bank (
	// clock and reset
	input  wire                          pclk,
	input  wire                          presetn,
	// apb
	input  wire                          psel,
	input  wire                          penable,
	input  wire                          pwrite,
	input  wire [`FCB_AW-1:0]            paddr,
	input  wire [`FCB_DW-1:0]            pwdata,
	output wire                          pready,
	output wire [`FCB_DW-1:0]            prdata,
	output wire                          pslverr,
	// filter side
	output reg                           chb_fir_en,
	output reg  signed [`FCB_CTAP_CW-1:0] chb_tap5_coeff,
	output reg  signed [`FCB_OTAP_CW-1:0] chb_tap6_coeff,
	output reg  signed [`FCB_OTAP_CW-1:0] chb_tap7_coeff,
	output reg  signed [`FCB_OTAP_CW-1:0] chb_tap8_coeff,
	output reg  signed [`FCB_OTAP_CW-1:0] chb_tap9_coeff,
	output reg                           coeff_upd
);
	localparam OW = `FCB_OTAP_W;
	localparam OC = `FCB_OTAP_CW;
	localparam N  = `FCB_OTAP_N;

	wire [`FCB_IW-1:0]       idx;
	wire                     wr_stb;
	reg                      hit;
	reg                      wr_ok;
	reg  [`FCB_DW-1:0]       rd_mux;

	wire                     ctap_wr;
	wire [`FCB_CTAP_W-1:0]   ctap_q;
	wire [`FCB_CTAP_W-1:0]   ctap_rd;
	wire [`FCB_CTAP_CW-1:0]  ctap_coeff;
	wire                     ctap_wrote;

	wire [N-1:0]             otap_wr;
	wire [N*OW-1:0]          otap_rd;
	wire [N*OC-1:0]          otap_coeff;
	wire [N-1:0]             otap_wrote;

	reg  [`FCB_CTRL_W-1:0]   ctrl_r;
	reg  [`FCB_CTRL_W-1:0]   ctrl_nxt;
	wire                     dual;
	wire                     hold;

	reg  [`FCB_CTAP_CW-1:0]  tap5_nxt;
	reg  [N*OC-1:0]          otap_nxt;
	reg                      en_nxt;
	wire                     all_zero;

	// bus front end
	fcb_apb_if u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr),
		.idx     (idx),
		.hit     (hit),
		.wr_ok   (wr_ok),
		.rd_data (rd_mux),
		.wr_stb  (wr_stb)
	);

	// center tap: reserved upper bits are stored and read back
	assign ctap_wr = wr_stb && (idx == `FCB_IDX_CTAP);

	fcb_coeff_reg #(
		.W     (`FCB_CTAP_W),
		.CW    (`FCB_CTAP_CW),
		.RMASK (`FCB_CTAP_RMASK)
	) u_ctap (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (ctap_wr),
		.wdata   (pwdata[`FCB_CTAP_W-1:0]),
		.q_r     (ctap_q),
		.rdata   (ctap_rd),
		.coeff   (ctap_coeff),
		.wrote_r (ctap_wrote)
	);

	// outer taps six to nine, one word index two apart
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_otap
			localparam integer TI = `FCB_IDX_TAP6 + i * `FCB_TAP_STEP;
			localparam [`FCB_IW-1:0] TIDX = TI[`FCB_IW-1:0];
			localparam [OW-1:0] RM = (i == N - 1) ? `FCB_TAP9_RMASK
			                                      : `FCB_OTAP_RMASK;

			assign otap_wr[i] = wr_stb && (idx == TIDX);

			fcb_coeff_reg #(
				.W     (OW),
				.CW    (OC),
				.RMASK (RM)
			) u_otap (
				.pclk    (pclk),
				.presetn (presetn),
				.wr_en   (otap_wr[i]),
				.wdata   (pwdata[OW-1:0]),
				.q_r     (),
				.rdata   (otap_rd[i*OW +: OW]),
				.coeff   (otap_coeff[i*OC +: OC]),
				.wrote_r (otap_wrote[i])
			);
		end
	endgenerate

	// control: dual mode enable and a hold bit for glitch-free reloads
	assign dual = ctrl_r[`FCB_CTRL_DUAL];
	assign hold = ctrl_r[`FCB_CTRL_HOLD];

	always @* begin
		ctrl_nxt = ctrl_r;
		if (wr_stb && (idx == `FCB_IDX_CTRL)) begin
			ctrl_nxt = pwdata[`FCB_CTRL_W-1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `FCB_CTRL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// address decode; status is read-only
	always @* begin
		hit   = 1'b1;
		wr_ok = 1'b1;
		case (idx)
			`FCB_IDX_CTAP : hit = 1'b1;
			`FCB_IDX_TAP6 : hit = 1'b1;
			`FCB_IDX_TAP7 : hit = 1'b1;
			`FCB_IDX_TAP8 : hit = 1'b1;
			`FCB_IDX_TAP9 : hit = 1'b1;
			`FCB_IDX_CTRL : hit = 1'b1;
			`FCB_IDX_STAT : wr_ok = 1'b0;
			default       : hit = 1'b0;
		endcase
	end

	assign all_zero = (ctap_q[`FCB_CTAP_CW-1:0] == {`FCB_CTAP_CW{1'b0}}) &&
	                  (otap_coeff == {N*OC{1'b0}});

	// read mux; narrow registers sit in the low bits
	always @* begin
		rd_mux = {`FCB_DW{1'b0}};
		case (idx)
			`FCB_IDX_CTAP : rd_mux[`FCB_CTAP_W-1:0] = ctap_rd;
			`FCB_IDX_TAP6 : rd_mux[OW-1:0] = otap_rd[0*OW +: OW];
			`FCB_IDX_TAP7 : rd_mux[OW-1:0] = otap_rd[1*OW +: OW];
			`FCB_IDX_TAP8 : rd_mux[OW-1:0] = otap_rd[2*OW +: OW];
			`FCB_IDX_TAP9 : rd_mux[OW-1:0] = otap_rd[3*OW +: OW];
			`FCB_IDX_CTRL : rd_mux[`FCB_CTRL_W-1:0] = ctrl_r;
			`FCB_IDX_STAT : rd_mux[6:0] = {all_zero, otap_wrote,
			                               ctap_wrote, chb_fir_en};
			default       : rd_mux = {`FCB_DW{1'b0}};
		endcase
	end

	// filter taps: zero weight outside dual mode, frozen while hold is set in dual mode
	always @* begin
		en_nxt   = dual;
		tap5_nxt = chb_tap5_coeff;
		otap_nxt = {chb_tap9_coeff, chb_tap8_coeff,
		            chb_tap7_coeff, chb_tap6_coeff};
		if (!dual) begin
			tap5_nxt = {`FCB_CTAP_CW{1'b0}};
			otap_nxt = {N*OC{1'b0}};
		end else if (!hold) begin
			tap5_nxt = ctap_coeff;
			otap_nxt = otap_coeff;
		end
	end

	// outputs are flops so the datapath never sees a half-written word
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chb_fir_en     <= 1'b0;
			chb_tap5_coeff <= {`FCB_CTAP_CW{1'b0}};
			chb_tap6_coeff <= {OC{1'b0}};
			chb_tap7_coeff <= {OC{1'b0}};
			chb_tap8_coeff <= {OC{1'b0}};
			chb_tap9_coeff <= {OC{1'b0}};
			coeff_upd      <= 1'b0;
		end else begin
			chb_fir_en     <= en_nxt;
			chb_tap5_coeff <= tap5_nxt;
			chb_tap6_coeff <= otap_nxt[0*OC +: OC];
			chb_tap7_coeff <= otap_nxt[1*OC +: OC];
			chb_tap8_coeff <= otap_nxt[2*OC +: OC];
			chb_tap9_coeff <= otap_nxt[3*OC +: OC];
			coeff_upd      <= (tap5_nxt != chb_tap5_coeff) ||
			                  (en_nxt != chb_fir_en) ||
			                  (otap_nxt != {chb_tap9_coeff, chb_tap8_coeff,
			                                chb_tap7_coeff, chb_tap6_coeff});
		end
	end
endmodule

// ### test/fcb_coeff_bank_assertions.sv
// fcb_coeff_bank_assertions.sv: port checker for the coefficient bank
// assumes zero-wait apb and taps that show one edge after the write edge
`timescale 1ns/10ps
module fcb_coeff_bank_chk (
	// clock and reset
	input wire logic               pclk,
	input wire logic               presetn,
	// apb
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [13:0]        paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pready,
	input wire logic [31:0]        prdata,
	input wire logic               pslverr,
	// filter side
	input wire logic               chb_fir_en,
	input wire logic signed [17:0] chb_tap5_coeff,
	input wire logic signed [11:0] chb_tap6_coeff,
	input wire logic signed [11:0] chb_tap7_coeff,
	input wire logic signed [11:0] chb_tap8_coeff,
	input wire logic signed [11:0] chb_tap9_coeff,
	input wire logic               coeff_upd
);
	// shadow of the control word: tap checks only hold while live and not frozen
	logic [1:0]  ctrl_r;
	wire         wr_acc = psel && penable && pwrite;
	wire         rd_set = psel && !penable;
	wire  [17:0] wd18 = pwdata[17:0];
	wire  [11:0] wd12 = pwdata[11:0];
	wire         wd0 = pwdata[0];
	wire  [66:0] outs = {chb_fir_en, chb_tap5_coeff, chb_tap6_coeff, chb_tap7_coeff,
		chb_tap8_coeff, chb_tap9_coeff};
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) ctrl_r <= 2'h0;
		else if (wr_acc && paddr == 14'h1180) ctrl_r <= pwdata[1:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_CTAP: assert property (wr_acc && paddr == 14'h1140 && ctrl_r == 2'h1
		|-> ##2 chb_tap5_coeff == $past(wd18, 2)) else $error("center tap wrong");
	AST_TAP6: assert property (wr_acc && paddr == 14'h114c && ctrl_r == 2'h1
		|-> ##2 chb_tap6_coeff == $past(wd12, 2)) else $error("tap six wrong");
	AST_TAP9: assert property (wr_acc && paddr == 14'h1164 && ctrl_r == 2'h1
		|-> ##2 chb_tap9_coeff == $past(wd12, 2)) else $error("tap nine wrong");
	AST_EN: assert property (wr_acc && paddr == 14'h1180 && !pwdata[1] && !ctrl_r[1]
		|-> ##2 chb_fir_en == $past(wd0, 2)) else $error("enable wrong");
	AST_OFF: assert property (!chb_fir_en |-> outs[65:0] == 66'h0)
		else $error("taps live while unused");
	AST_UPD: assert property (coeff_upd == $changed(outs))
		else $error("update pulse wrong");
	AST_ERR: assert property (rd_set && (paddr == 14'h1148 || paddr[1:0] != 2'h0)
		|=> pslverr && prdata == 32'h0) else $error("hole not refused");
	AST_RD9: assert property (rd_set && !pwrite && paddr == 14'h1164
		|=> !prdata[11] && !pslverr) else $error("tap nine msb read");
	AST_RDY: assert property (psel && penable |-> pready)
		else $error("access phase not ready");
	AST_HOLD: assert property (ctrl_r == 2'h3 |=> $stable(outs))
		else $error("taps moved while held");
endmodule

bind fcb_coeff_bank fcb_coeff_bank_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .prdata, .pslverr, .chb_fir_en, .chb_tap5_coeff,
	.chb_tap6_coeff, .chb_tap7_coeff, .chb_tap8_coeff, .chb_tap9_coeff, .coeff_upd);

// ### test/fcb_coeff_bank_tb.sv
// fcb_coeff_bank_tb.sv: self-checking bench for the coefficient bank
// assumes zero-wait apb and taps that show one edge after the write edge
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module fcb_coeff_bank_tb;
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [13:0]        paddr = 14'h0;
	logic [31:0]        pwdata = 32'h0;
	wire                pready;
	wire  [31:0]        prdata;
	wire                pslverr;
	wire                chb_fir_en;
	wire  signed [17:0] chb_tap5_coeff;
	wire  signed [11:0] chb_tap6_coeff;
	wire  signed [11:0] chb_tap7_coeff;
	wire  signed [11:0] chb_tap8_coeff;
	wire  signed [11:0] chb_tap9_coeff;
	wire                coeff_upd;
	wire  [66:0]        outs = {chb_fir_en, chb_tap5_coeff, chb_tap6_coeff, chb_tap7_coeff,
		chb_tap8_coeff, chb_tap9_coeff};
	int                 err_total = 0;
	int                 checks = 0;
	logic [31:0]        rd;
	logic               er;

	always #4 pclk = ~pclk;

	fcb_coeff_bank uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .chb_fir_en, .chb_tap5_coeff, .chb_tap6_coeff, .chb_tap7_coeff,
		.chb_tap8_coeff, .chb_tap9_coeff, .coeff_upd);

	task automatic close_out;
		$display("errors %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one apb transfer; read data and error taken at the access edge
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_total++;
			close_out;
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// taps move one edge after the write edge, so settle two edges
	task automatic settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask

	task automatic do_reset;
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	task automatic t_zero;
		logic [13:0] a[6] = '{14'h1140, 14'h114c, 14'h1154, 14'h115c, 14'h1164, 14'h1180};
		foreach (a[i]) begin
			apb(1'b0, a[i], 32'h0);
			`CHK("reset read", 32'h0, rd)
		end
		`CHK("reset taps", 67'h0, outs)
		apb(1'b0, 14'h1184, 32'h0);
		`CHK("reset stat", 32'h00000040, rd)
	endtask

	task automatic t_mask;
		apb(1'b1, 14'h1180, 32'h0);
		apb(1'b1, 14'h1140, 32'hffffffff);
		apb(1'b0, 14'h1140, 32'h0);
		`CHK("center read", 32'h00ffffff, rd)
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 14'h114c + 14'(8 * i), 32'hffffffff);
			apb(1'b0, 14'h114c + 14'(8 * i), 32'h0);
			`CHK("outer read", (i == 3) ? 32'h0000f7ff : 32'h0000ffff, rd)
			`CHK("outer err", 1'b0, er)
		end
		settle;
		`CHK("single mode taps", 67'h0, outs)
	endtask

	task automatic t_dual;
		apb(1'b1, 14'h1180, 32'h1);
		settle;
		`CHK("dual all ones", {67{1'b1}}, outs)
		apb(1'b1, 14'h1140, 32'h00020005);
		apb(1'b1, 14'h114c, 32'h00000806);
		apb(1'b1, 14'h1154, 32'h00000007);
		apb(1'b1, 14'h115c, 32'h00000f08);
		apb(1'b1, 14'h1164, 32'h00000809);
		settle;
		`CHK("tap map", {1'b1, 18'h20005, 12'h806, 12'h007, 12'hf08, 12'h809}, outs)
		`CHK("center sign", 1'b1, chb_tap5_coeff < 0)
		apb(1'b0, 14'h1164, 32'h0);
		`CHK("tap9 read", 32'h00000009, rd)
		apb(1'b0, 14'h1184, 32'h0);
		`CHK("dual stat", 32'h0000003f, rd)
		apb(1'b1, 14'h1180, 32'h3);
		apb(1'b1, 14'h114c, 32'h00000123);
		settle;
		`CHK("held tap", 12'h806, chb_tap6_coeff)
		apb(1'b0, 14'h114c, 32'h0);
		`CHK("held read", 32'h00000123, rd)
		apb(1'b1, 14'h1180, 32'h1);
		settle;
		`CHK("released tap", 12'h123, chb_tap6_coeff)
		apb(1'b1, 14'h1180, 32'h0);
		settle;
		`CHK("off taps", 67'h0, outs)
	endtask

	task automatic t_err;
		logic [13:0] a[4] = '{14'h1144, 14'h1148, 14'h1150, 14'h1142};
		foreach (a[i]) begin
			apb(1'b1, a[i], 32'hffffffff);
			`CHK("error flag", 1'b1, er)
			apb(1'b0, a[i], 32'h0);
			`CHK("error data", 32'h0, rd)
		end
		apb(1'b1, 14'h1184, 32'hffffffff);
		`CHK("stat write err", 1'b1, er)
		apb(1'b0, 14'h1140, 32'h0);
		`CHK("center kept", 32'h00020005, rd)
	endtask

	initial begin
		do_reset;
		t_zero;
		t_mask;
		t_dual;
		t_err;
		do_reset;
		t_zero;
		close_out;
	end
endmodule
